/* File: design/sync_src_pkg.sv */
package sync_src_pkg;

  // ==========================================================
  // Sources and carriers
  typedef enum logic [1:0] {
    SRC_WORD_CLOCK,
    SRC_OPTICAL_MC,
    SRC_OPTICAL_SYNC,
    SRC_SPDIF
  } src_e;

  localparam int NUM_SRC = 4;
  localparam int RATE_W = 17;

  typedef struct packed {
    logic locked;
    logic synced;
    logic [RATE_W-1:0] rate_hz;
  } src_stat_s;

  typedef struct packed {
    logic auto_mode;
    src_e pref;
    logic [RATE_W-1:0] sys_rate_hz;
  } cfg_s;

  // ==========================================================
  // Per-input report codes
  localparam logic [1:0] ST_NO_LOCK = 2'h0;
  localparam logic [1:0] ST_LOCK = 2'h1;
  localparam logic [1:0] ST_SYNC = 2'h2;

  // ==========================================================
  // Rates in Hz and channel counts
  localparam logic [RATE_W-1:0] RATE_MIN_HZ = 17'd28000;
  localparam logic [RATE_W-1:0] RATE_MAX_HZ = 17'd103000;
  localparam logic [RATE_W-1:0] WCLK_MAX_HZ = 17'd105000;
  localparam logic [RATE_W-1:0] DOUBLE_MIN_HZ = 17'd88200;
  localparam logic [RATE_W-1:0] RATE_TOL_HZ = 17'd500;
  localparam logic [RATE_W-1:0] SYS_RATE_RST = 17'd48000;
  localparam logic [3:0] CHANS_SINGLE = 4'h8;
  localparam logic [3:0] CHANS_MUX = 4'h4;

  // ==========================================================
  // Register map (byte addresses) and fields
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RATE = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_ACTIVE = 8'h0c;
  localparam int CTRL_AUTO_BIT = 0;
  localparam int CTRL_PREF_LSB = 1;
  localparam int ACT_SLAVE_BIT = 2;
  localparam int ACT_MUX_BIT = 3;
  localparam int ACT_CHANS_LSB = 4;
  localparam int ACT_RATE_LSB = 8;
  localparam logic CTRL_AUTO_RST = 1'b1;

endpackage

/* File: design/sync_pick.sv */
`timescale 1ns/1ps
module sync_pick
  import sync_src_pkg::*;
(
  input wire logic [NUM_SRC-1:0] valid_i,
  input wire src_e pref_i,
  output src_e pick_o,
  output logic any_o
);

  // ==========================================================
  // Scan from the preferred input onward, first valid one wins
  always_comb begin
    logic [1:0] idx;
    idx = 2'h0;
    pick_o = pref_i;
    any_o = 1'b0;
    for (int k = NUM_SRC - 1; k >= 0; k--) begin
      idx = 2'(pref_i + 2'(k));
      if (valid_i[idx]) begin
        pick_o = src_e'(idx);
        any_o = 1'b1;
      end
    end
  end

endmodule

/* File: design/sync_source_selector.sv */
// Design decisions made here: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
module sync_source_selector
  import sync_src_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic [NUM_SRC-1:0] lock_pin_i,
  input wire logic [NUM_SRC-1:0] sync_pin_i,
  input wire logic [NUM_SRC*RATE_W-1:0] rate_hz_i,
  input wire logic [2:0] map_audio_ch_i,
  output logic [3:0] map_link_first_o,
  output logic [1:0] ref_src_o,
  output logic use_recovered_o,
  output logic sample_mux_o
);

  // ==========================================================
  // Pin synchronisers
  logic [NUM_SRC-1:0] lock_m_q, lock_s_q, sync_m_q, sync_s_q;
  logic [NUM_SRC-1:0] lock_m_d, lock_s_d, sync_m_d, sync_s_d;

  always_comb begin
    lock_m_d = lock_pin_i;
    lock_s_d = lock_m_q;
    sync_m_d = sync_pin_i;
    sync_s_d = sync_m_q;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      lock_m_q <= '0;
      lock_s_q <= '0;
      sync_m_q <= '0;
      sync_s_q <= '0;
    end else begin
      lock_m_q <= lock_m_d;
      lock_s_q <= lock_s_d;
      sync_m_q <= sync_m_d;
      sync_s_q <= sync_s_d;
    end
  end

  // ==========================================================
  // Configuration and bus slave
  cfg_s cfg_q, cfg_d;
  logic wr_pend_q, wr_pend_d;
  logic [7:0] wr_addr_q, wr_addr_d;
  logic [31:0] rdata_q, rdata_d;
  logic [7:0] stat_q, stat_d;
  src_e sel_q, sel_d;
  logic slave_q, slave_d;
  logic mux_q, mux_d;
  logic [RATE_W-1:0] act_rate_q, act_rate_d;
  logic [3:0] map_q, map_d;
  logic addr_ok;
  logic [7:0] word_addr;

  assign word_addr = {haddr_i[7:2], 2'h0};
  assign addr_ok = hsel_i && htrans_i[1] && hready_i;

  function automatic logic [31:0] read_word(input logic [7:0] a, input cfg_s c, input logic [7:0] st,
                                            input src_e s, input logic sl, input logic mx,
                                            input logic [RATE_W-1:0] r);
    logic [31:0] w;
    w = 32'h0;
    unique case (a)
      OFS_CTRL: begin
        w[CTRL_AUTO_BIT] = c.auto_mode;
        w[CTRL_PREF_LSB +: 2] = c.pref;
      end
      OFS_RATE: w[RATE_W-1:0] = c.sys_rate_hz;
      OFS_STATUS: w[7:0] = st;
      OFS_ACTIVE: begin
        w[1:0] = s;
        w[ACT_SLAVE_BIT] = sl;
        w[ACT_MUX_BIT] = mx;
        w[ACT_CHANS_LSB +: 4] = mx ? CHANS_MUX : CHANS_SINGLE;
        w[ACT_RATE_LSB +: RATE_W] = r;
      end
      default: w = 32'h0;
    endcase
    return w;
  endfunction

  always_comb begin
    cfg_d = cfg_q;
    wr_pend_d = 1'b0;
    wr_addr_d = wr_addr_q;
    rdata_d = rdata_q;
    if (wr_pend_q) begin
      unique case (wr_addr_q)
        OFS_CTRL: begin
          cfg_d.auto_mode = hwdata_i[CTRL_AUTO_BIT];
          cfg_d.pref = src_e'(hwdata_i[CTRL_PREF_LSB +: 2]);
        end
        OFS_RATE: cfg_d.sys_rate_hz = hwdata_i[RATE_W-1:0];
        default: cfg_d = cfg_q;
      endcase
    end
    if (addr_ok) begin
      wr_pend_d = hwrite_i;
      wr_addr_d = word_addr;
      if (!hwrite_i) begin
        rdata_d = read_word(word_addr, cfg_q, stat_q, sel_q, slave_q, mux_q, act_rate_q);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cfg_q <= '{auto_mode: CTRL_AUTO_RST, pref: SRC_WORD_CLOCK, sys_rate_hz: SYS_RATE_RST};
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h0;
      rdata_q <= 32'h0;
    end else begin
      cfg_q <= cfg_d;
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      rdata_q <= rdata_d;
    end
  end

  assign hrdata_o = rdata_q;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

  // ==========================================================
  // Input qualification
  src_stat_s src[NUM_SRC];
  logic [NUM_SRC-1:0] valid;
  logic double_rate;
  logic mux_req;

  function automatic logic near(input logic [RATE_W-1:0] a, input logic [RATE_W-1:0] b);
    logic [RATE_W-1:0] d;
    d = (a > b) ? RATE_W'(a - b) : RATE_W'(b - a);
    return d <= RATE_TOL_HZ;
  endfunction

  assign double_rate = cfg_q.sys_rate_hz >= DOUBLE_MIN_HZ;
  assign mux_req = double_rate && (cfg_q.pref == SRC_OPTICAL_MC);

  always_comb begin
    logic [RATE_W-1:0] hi;
    logic [RATE_W-1:0] eff;
    hi = RATE_MAX_HZ;
    eff = '0;
    stat_d = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      src[i].locked = lock_s_q[i];
      src[i].synced = sync_s_q[i];
      src[i].rate_hz = rate_hz_i[i*RATE_W +: RATE_W];
      hi = (i == int'(SRC_WORD_CLOCK)) ? WCLK_MAX_HZ : RATE_MAX_HZ;
      // Multiplexed optical link runs at half the system rate
      eff = (mux_req && i == int'(SRC_OPTICAL_MC)) ? RATE_W'({src[i].rate_hz, 1'b0}) : src[i].rate_hz;
      valid[i] = src[i].locked && src[i].rate_hz >= RATE_MIN_HZ && src[i].rate_hz <= hi
                 && near(eff, cfg_q.sys_rate_hz);
      stat_d[2*i +: 2] = !src[i].locked ? ST_NO_LOCK : (src[i].synced ? ST_SYNC : ST_LOCK);
    end
  end

  // ==========================================================
  // Reference selection
  src_e pick;
  logic any_valid;

  sync_pick u_pick (
    .valid_i(valid),
    .pref_i(cfg_q.pref),
    .pick_o(pick),
    .any_o(any_valid)
  );

  always_comb begin
    // Re-evaluated every cycle, so a lock pin change reaches the selection three clocks later
    sel_d = any_valid ? pick : cfg_q.pref;
    slave_d = cfg_q.auto_mode && any_valid;
    act_rate_d = slave_d ? src[pick].rate_hz : cfg_q.sys_rate_hz;
    mux_d = mux_req;
    // Same map serves record and playback paths
    map_d = mux_q ? {map_audio_ch_i, 1'b0} : {1'b0, map_audio_ch_i};
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      stat_q <= '0;
      sel_q <= SRC_WORD_CLOCK;
      slave_q <= 1'b0;
      mux_q <= 1'b0;
      act_rate_q <= '0;
      map_q <= '0;
    end else begin
      stat_q <= stat_d;
      sel_q <= sel_d;
      slave_q <= slave_d;
      mux_q <= mux_d;
      act_rate_q <= act_rate_d;
      map_q <= map_d;
    end
  end

  // Every input keeps receiving; only the clock reference is steered
  assign ref_src_o = sel_q;
  assign use_recovered_o = slave_q;
  assign sample_mux_o = mux_q;
  assign map_link_first_o = map_q;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  sequence ctrl_master_write;
    wr_pend_q && wr_addr_q == OFS_CTRL && !hwdata_i[CTRL_AUTO_BIT];
  endsequence

  sequence ctrl_auto_write;
    wr_pend_q && wr_addr_q == OFS_CTRL && hwdata_i[CTRL_AUTO_BIT];
  endsequence

  sequence active_read_taken;
    addr_ok && !hwrite_i && word_addr == OFS_ACTIVE;
  endsequence

  // Pins pass two synchronising flops, so a level must hold three samples before status shows it
  sequence spdif_lock_low;
    (!lock_pin_i[SRC_SPDIF]) [*3];
  endsequence

  sequence optical_sync_high;
    (lock_pin_i[SRC_OPTICAL_SYNC] && sync_pin_i[SRC_OPTICAL_SYNC]) [*3];
  endsequence

  sequence optical_lock_only;
    (lock_pin_i[SRC_OPTICAL_SYNC] && !sync_pin_i[SRC_OPTICAL_SYNC]) [*3];
  endsequence

  master_mode_a: assert property (ctrl_master_write ##1 1'b1 |=> !use_recovered_o)
    else $error("master mode kept slave");
  auto_write_a: assert property (ctrl_auto_write |=> cfg_q.auto_mode)
    else $error("automatic mode not stored");
  rate_write_a: assert property (wr_pend_q && wr_addr_q == OFS_RATE |=>
    cfg_q.sys_rate_hz == $past(hwdata_i[RATE_W-1:0])) else $error("playback rate not stored");
  pref_wins_a: assert property (cfg_q.auto_mode && valid[cfg_q.pref] |=> slave_q && sel_q == $past(cfg_q.pref))
    else $error("valid preferred input not chosen");
  next_valid_a: assert property (cfg_q.auto_mode && !valid[cfg_q.pref] && valid[2'(cfg_q.pref + 2'h1)]
    |=> sel_q == src_e'(2'($past(cfg_q.pref) + 2'h1))) else $error("wrong fallback input");
  none_master_a: assert property (valid == '0 |=> !use_recovered_o) else $error("slave without valid input");
  lock_status_a: assert property (!lock_pin_i[0] ##1 !lock_pin_i[0] ##1 !lock_pin_i[0]
    |=> stat_q[1:0] == ST_NO_LOCK) else $error("status shows lock without lock");
  sync_status_a: assert property (optical_sync_high |=> stat_q[5:4] == ST_SYNC)
    else $error("sync status missing");
  lock_only_a: assert property (optical_lock_only |=> stat_q[5:4] == ST_LOCK)
    else $error("lock status missing");
  low_rate_a: assert property (src[1].rate_hz < RATE_MIN_HZ |-> !valid[1])
    else $error("rate below range accepted");
  high_rate_a: assert property (src[SRC_OPTICAL_SYNC].rate_hz > RATE_MAX_HZ |-> !valid[SRC_OPTICAL_SYNC])
    else $error("rate above range accepted");
  wclk_top_a: assert property (src[SRC_WORD_CLOCK].locked && src[SRC_WORD_CLOCK].rate_hz == WCLK_MAX_HZ
    && cfg_q.sys_rate_hz == WCLK_MAX_HZ |-> valid[SRC_WORD_CLOCK]) else $error("word clock top rate refused");
  mux_on_a: assert property (mux_req [*2] |-> sample_mux_o) else $error("multiplexing not enabled");
  mux_half_a: assert property (mux_req && src[SRC_OPTICAL_MC].locked
    && src[SRC_OPTICAL_MC].rate_hz == (cfg_q.sys_rate_hz >> 1) |-> valid[SRC_OPTICAL_MC])
    else $error("half-rate optical input refused");
  active_chans_a: assert property (active_read_taken |=>
    hrdata_o[ACT_CHANS_LSB +: 4] == ($past(sample_mux_o) ? CHANS_MUX : CHANS_SINGLE))
    else $error("channel count wrong");
  slave_flag_a: assert property (active_read_taken |=>
    hrdata_o[ACT_SLAVE_BIT] == $past(use_recovered_o) && hrdata_o[1:0] == $past(ref_src_o))
    else $error("active source report wrong");
  master_rate_a: assert property (!(cfg_q.auto_mode && any_valid) |=> act_rate_q == $past(cfg_q.sys_rate_hz))
    else $error("master rate report wrong");
  read_hold_a: assert property (!(addr_ok && !hwrite_i) |=> $stable(hrdata_o)) else $error("read data moved");
  spdif_drop_a: assert property (spdif_lock_low |=>
    !valid[SRC_SPDIF] && !(use_recovered_o && ref_src_o == 2'h3)) else $error("unlocked input kept as reference");
  chan_map_a: assert property (sample_mux_o |=> map_link_first_o == {$past(map_audio_ch_i), 1'b0})
    else $error("multiplexed map wrong");
  plain_map_a: assert property (!sample_mux_o |=> map_link_first_o == {1'b0, $past(map_audio_ch_i)})
    else $error("plain map wrong");

endmodule

/* File: tb/ext_sources.sv */
`timescale 1ns/1ps
module ext_sources
  import sync_src_pkg::*;
(
  input wire logic clk_i,
  input wire logic [NUM_SRC-1:0] lock_req_i,
  input wire logic [NUM_SRC-1:0] sync_req_i,
  input wire logic [NUM_SRC*RATE_W-1:0] rate_req_i,
  output logic [NUM_SRC-1:0] lock_o,
  output logic [NUM_SRC-1:0] sync_o,
  output logic [NUM_SRC*RATE_W-1:0] rate_o
);
  // ==========================================================
  // Far-side receivers, all running at once
  initial begin
    lock_o = '0;
    sync_o = '0;
    rate_o = '0;
  end
  always @(posedge clk_i) begin
    lock_o <= lock_req_i;
    // A device slaved to our clock only reads as synchronous while locked
    sync_o <= sync_req_i & lock_req_i;
    for (int i = 0; i < NUM_SRC; i++) begin
      // Unlocked receivers alternate between the last good rate and its bitwise inverse
      rate_o[i*RATE_W +: RATE_W] <= lock_req_i[i] ? rate_req_i[i*RATE_W +: RATE_W] : ~rate_o[i*RATE_W +: RATE_W];
    end
  end
endmodule

/* File: tb/sync_source_selector_tb.sv */
`timescale 1ns/1ps
module sync_source_selector_tb;
  import sync_src_pkg::*;
  logic clk, srst, hsel, hwrite, hreadyout, hresp, use_rec, smux, auto, mx, any;
  logic [31:0] haddr, hwdata, hrdata, rd, exp_act;
  logic [1:0] htrans, ref_src, pref, sel;
  logic [3:0] lock_req, sync_req, lock, sync, map_first;
  logic [67:0] rate_req, rate;
  logic [2:0] map_ch;
  logic [16:0] sysr, tbl [6];
  logic [31:0] st;
  int fails, tests_run, seed, r;

  sync_source_selector DUT (.clk_i(clk), .srst_i(srst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata),
    .hreadyout_o(hreadyout), .hresp_o(hresp), .lock_pin_i(lock), .sync_pin_i(sync), .rate_hz_i(rate),
    .map_audio_ch_i(map_ch), .map_link_first_o(map_first), .ref_src_o(ref_src), .use_recovered_o(use_rec),
    .sample_mux_o(smux));
  ext_sources far (.clk_i(clk), .lock_req_i(lock_req), .sync_req_i(sync_req), .rate_req_i(rate_req),
    .lock_o(lock), .sync_o(sync), .rate_o(rate));

  // ==========================================================
  // Helpers
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  // Valid: locked, rate in range, near playback rate (optical doubled when muxing)
  function automatic logic src_ok(int i);
    logic [17:0] m;
    int d;
    m = rate_req[i*17 +: 17];
    d = int'((i == 1 && mx) ? m * 2 : m) - int'(sysr);
    return lock_req[i] && m >= 28000 && m <= ((i == 0) ? 105000 : 103000) && d <= 500 && d >= -500;
  endfunction
  task automatic complete_run;
    if (fails == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #(5ns * 30000);
    fails++;
    complete_run;
  end

  // ==========================================================
  // Main sequence
  initial begin
    tbl = '{17'd27800, 17'd28000, 17'd48000, 17'd96000, 17'd103000, 17'd105000};
    seed = 72;
    {hsel, hwrite, htrans, haddr, hwdata, lock_req, sync_req, rate_req, map_ch} = '0;
    srst = 1'b1;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    ahb(1'b1, OFS_ACTIVE, 32'hffffffff, rd);
    ahb(1'b0, OFS_CTRL, 32'h0, rd);
    chk(rd, 32'h1);
    ahb(1'b0, OFS_RATE, 32'h0, rd);
    chk(rd, 32'd48000);
    ahb(1'b0, 8'h10, 32'h0, rd);
    chk(rd, 32'h0);
    repeat (90) begin
      r = $random(seed);
      auto = r[0];
      pref = r[2:1];
      sysr = tbl[r[7:4] % 6];
      if (sysr >= 88200 && r[8]) pref = 2'h1;
      mx = sysr >= 88200 && pref == 2'h1;
      @(posedge clk);
      for (int i = 0; i < 4; i++) begin
        r = $random(seed);
        lock_req[i] <= r[0];
        sync_req[i] <= r[1];
        rate_req[i*17 +: 17] <= ((i == 1 && mx) ? sysr / 2 : sysr) + (r[3:2] == 1 ? 500 : r[3:2] == 2 ? 501 : 0);
      end
      map_ch <= r[6:4];
      ahb(1'b1, OFS_CTRL, {29'h0, pref, auto}, rd);
      ahb(1'b1, OFS_RATE, {15'h0, sysr}, rd);
      repeat (6) @(posedge clk);
      any = 1'b0;
      sel = pref;
      st = '0;
      for (int k = 3; k >= 0; k--) begin
        if (src_ok((pref + k) % 4)) begin
          any = 1'b1;
          sel = 2'((pref + k) % 4);
        end
        st[2*k +: 2] = !lock_req[k] ? ST_NO_LOCK : sync_req[k] ? ST_SYNC : ST_LOCK;
      end
      chk(use_rec, auto & any);
      chk(smux, mx);
      chk(map_first, mx ? {map_ch, 1'b0} : {1'b0, map_ch});
      chk(ref_src, sel);
      ahb(1'b0, OFS_STATUS, 32'h0, rd);
      chk(rd, st);
      exp_act = {7'h0, (auto & any) ? rate_req[sel*17 +: 17] : sysr, mx ? CHANS_MUX : CHANS_SINGLE,
                 mx, auto & any, sel};
      ahb(1'b0, OFS_ACTIVE, 32'h0, rd);
      chk(rd, exp_act);
      chk({hreadyout, hresp}, 32'h2);
    end
    complete_run;
  end
endmodule
